// File: rtl/latched_driver_pkg.sv
`default_nettype none
package latched_driver_pkg;
	localparam int unsigned CHANNELS       = 8;
	localparam int unsigned MCLK_HZ        = 100_000_000;
	// least overcurrent duration that may shut a channel down
	localparam int unsigned OVC_FILTER_NS  = 2000;
	localparam int unsigned OVC_FILTER_CYC =
		(OVC_FILTER_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned OVC_CNT_W      = 8;
	// reset values of the shift register and latches
	localparam logic [7:0]  SHIFT_RST      = 8'h00;
	localparam logic [7:0]  LATCH_RST      = 8'h00;
	localparam logic [7:0]  FAULT_RST      = 8'h00;
	localparam logic [2:0]  SYNC_RST       = 3'h0;
endpackage
`default_nettype wire

// File: rtl/serial_latched_driver_ctrl.sv
// Notes on behaviour
// - eight latches, one per output channel
// - overcurrent turns off that channel, flags low
// - overcurrent stays latched until enable pulse
// - overcurrent shorter than 2 us ignored
// - over-temperature turns all off, flags low
// - low supply acts like enable high
// - zeroing clears one shift stage per serial clock, latches only after strobe
// - latch-load high copies shift register
// - enable low follows latches, high clears
// - last stage drives serial output
// - fault flag is open-drain, active low
// - serial clock of 3.3 MHz accepted
// - rising serial clock shifts data in
// - zeroing shifts zeros regardless of data
// - enable high keeps latch, register contents
// - over-temperature recovers without reset pulse
`default_nettype none
module serial_latched_driver_ctrl
	import latched_driver_pkg::*;
(
	input  wire logic                mclk_in,
	input  wire logic                rst_n_in,
	input  wire logic                sclk_in,
	input  wire logic                sdata_in,
	input  wire logic                zero_in,
	input  wire logic                strobe_in,
	input  wire logic                oe_reset_in,
	input  wire logic [CHANNELS-1:0] overcurrent_in,
	input  wire logic                overtemp_in,
	input  wire logic                low_supply_lockout_in,
	output logic      [CHANNELS-1:0] channel_on_out,
	output logic                     sdata_out,
	output logic                     fault_flag_n_out,
	output logic                     fault_flag_oe_out
);

	// all pins travel as one word through three flops; a change counts
	// only once stages two and three agree, so a one-cycle glitch on any
	// pin is never acted upon
	localparam int unsigned PIN_W = CHANNELS + 7;
	logic [PIN_W-1:0]    pin_raw;
	logic [PIN_W-1:0]    pin_s1_q, pin_s1_d;
	logic [PIN_W-1:0]    pin_s2_q, pin_s2_d;
	logic [PIN_W-1:0]    pin_s3_q, pin_s3_d;
	logic [PIN_W-1:0]    pin_lvl_q, pin_lvl_d;
	logic                sdat_f, zero_f, strb_f, oe_f, ot_f, lsl_f, sclk_f;
	logic                sclk_prev;
	logic [CHANNELS-1:0] ovc_f;

	// word order fixes where each filtered level sits
	assign pin_raw = {low_supply_lockout_in, overtemp_in, oe_reset_in,
		strobe_in, zero_in, sdata_in, sclk_in, overcurrent_in};
	assign {lsl_f, ot_f, oe_f, strb_f, zero_f, sdat_f, sclk_f, ovc_f} =
		pin_lvl_d;
	assign sclk_prev = pin_lvl_q[CHANNELS];

	// stages shift; disagreement between two and three holds the level
	always_comb begin
		pin_s1_d  = pin_raw;
		pin_s2_d  = pin_s1_q;
		pin_s3_d  = pin_s2_q;
		pin_lvl_d = pin_lvl_q;
		for (int i = 0; i < PIN_W; i++) begin
			if (pin_s2_q[i] == pin_s3_q[i]) begin
				pin_lvl_d[i] = pin_s3_q[i];
			end
		end
	end

	// synchroniser and filtered-level flops
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			pin_s1_q  <= '0;
			pin_s2_q  <= '0;
			pin_s3_q  <= '0;
			pin_lvl_q <= '0;
		end else begin
			pin_s1_q  <= pin_s1_d;
			pin_s2_q  <= pin_s2_d;
			pin_s3_q  <= pin_s3_d;
			pin_lvl_q <= pin_lvl_d;
		end
	end

	// data sampled at the stage matching the clock's filtered edge;
	// 10 ns sampling leaves wide margin over a 3.3 MHz serial clock
	logic sclk_rise;
	assign sclk_rise = sclk_f & ~sclk_prev;

	// shift register and output latches
	logic [CHANNELS-1:0] shift_q, shift_d, latch_q, latch_d;
	logic                dis_eff;

	// low supply behaves exactly as a held-high enable/reset
	assign dis_eff = oe_f | lsl_f;

	always_comb begin
		shift_d = shift_q;
		latch_d = latch_q;
		if (sclk_rise) begin
			// zeroing forces a zero in, no matter the data pin
			shift_d = {shift_q[CHANNELS-2:0],
				sdat_f & ~zero_f};
		end
		// transparent while strobe is high; disable leaves contents alone
		if (strb_f) begin
			latch_d = shift_q;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			shift_q <= SHIFT_RST;
			latch_q <= LATCH_RST;
		end else begin
			shift_q <= shift_d;
			latch_q <= latch_d;
		end
	end

	// last stage flows out for chaining further devices
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			sdata_out <= 1'b0;
		end else begin
			sdata_out <= shift_d[CHANNELS-1];
		end
	end

	// overcurrent filter counters and latched per-channel faults
	logic [OVC_CNT_W-1:0] ovc_cnt_q [CHANNELS];
	logic [OVC_CNT_W-1:0] ovc_cnt_d [CHANNELS];
	logic [CHANNELS-1:0]  trip_q, trip_d;

	always_comb begin
		trip_d = trip_q;
		for (int i = 0; i < CHANNELS; i++) begin
			ovc_cnt_d[i] = ovc_cnt_q[i];
			// a pulse under the filter time restarts the count
			if (!ovc_f[i]) begin
				ovc_cnt_d[i] = '0;
			end else if (ovc_cnt_q[i] < OVC_CNT_W'(OVC_FILTER_CYC)) begin
				ovc_cnt_d[i] = ovc_cnt_q[i] + 1'b1;
			end
			// enable/reset high clears; a trip in that cycle loses, since
			// the channel is off anyway while the pin stays high
			if (dis_eff) begin
				trip_d[i] = 1'b0;
			end else if (ovc_cnt_q[i] == OVC_CNT_W'(OVC_FILTER_CYC)) begin
				trip_d[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			trip_q <= FAULT_RST;
			for (int i = 0; i < CHANNELS; i++) begin
				ovc_cnt_q[i] <= '0;
			end
		end else begin
			trip_q <= trip_d;
			for (int i = 0; i < CHANNELS; i++) begin
				ovc_cnt_q[i] <= ovc_cnt_d[i];
			end
		end
	end

	// outputs: latch gated by enable, per-channel trip and overheat
	logic [CHANNELS-1:0] on_d;
	logic                flag_low_d;

	always_comb begin
		if (dis_eff || ot_f) begin
			on_d = '0;
		end else begin
			on_d = latch_q & ~trip_q;
		end
		flag_low_d = (|trip_q) | ot_f;
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			channel_on_out    <= '0;
			fault_flag_oe_out <= 1'b0;
		end else begin
			channel_on_out    <= on_d;
			fault_flag_oe_out <= flag_low_d;
		end
	end
	// open drain: only ever pulls low
	assign fault_flag_n_out = 1'b0;

	// helper flags over the filter counters, read only by the checks below
	logic [CHANNELS-1:0] ovc_full, ovc_zero;

	always_comb begin
		ovc_full = '0;
		ovc_zero = '0;
		for (int i = 0; i < CHANNELS; i++) begin
			ovc_full[i] = ovc_cnt_q[i] == OVC_CNT_W'(OVC_FILTER_CYC);
			ovc_zero[i] = ovc_cnt_q[i] == '0;
		end
	end

	// assertions; of the named steps only s_trip_seen is shared, by two properties
	sequence s_trip_seen;
		trip_q != '0;
	endsequence

	sequence s_serial_edge;
		sclk_rise;
	endsequence

	sequence s_load_open;
		strb_f;
	endsequence

	a_tripped_channel_off: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		s_trip_seen |=> (channel_on_out & $past(trip_q)) == '0)
		else $error("tripped channel still on");

	a_flag_follows_trip: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		s_trip_seen |=> fault_flag_oe_out)
		else $error("fault flag not pulled low");

	a_trip_held_latch: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		!dis_eff |=> (trip_q & $past(trip_q)) == $past(trip_q))
		else $error("trip dropped without reset pulse");

	a_short_pulse_ignored: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		!dis_eff |=> (trip_q & ~$past(trip_q | ovc_full)) == '0)
		else $error("trip before filter time");

	a_filter_count_clear: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		1'b1 |=> (ovc_zero | $past(ovc_f)) == '1)
		else $error("filter count kept after pulse ended");

	a_overheat_all_off: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		ot_f |=> channel_on_out == '0 && fault_flag_oe_out)
		else $error("overheat left outputs on");

	a_lockout_clears: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		lsl_f |=> trip_q == '0)
		else $error("lockout did not clear faults");

	a_zero_shift_in: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		sclk_rise && zero_f |=> !shift_q[0])
		else $error("zeroing shifted a one");

	a_strobe_loads: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		s_load_open |=> latch_q == $past(shift_q))
		else $error("latch not loaded on strobe");

	a_shift_moves: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		s_serial_edge |=> shift_q[7:1] == $past(shift_q[6:0]))
		else $error("shift did not advance");

	a_disable_keeps_data: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		dis_eff && !strb_f |=> latch_q == $past(latch_q))
		else $error("disable altered latches");

	a_data_shift_in: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		sclk_rise && !zero_f |=> shift_q[0] == $past(sdat_f))
		else $error("serial data not captured");

	a_serial_out_last: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		1'b1 |-> sdata_out == shift_q[7])
		else $error("serial output not last stage");

	a_enable_all_off: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		oe_f |=> channel_on_out == '0)
		else $error("enable high left outputs on");

	a_outputs_follow: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		!dis_eff && !ot_f |=> channel_on_out == $past(latch_q & ~trip_q))
		else $error("outputs not following latches");

	a_overheat_recovers: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		!ot_f && trip_q == '0 |=> !fault_flag_oe_out)
		else $error("flag held without a fault");

	a_latch_holds_closed: assert property (
		@(posedge mclk_in) disable iff (!rst_n_in)
		!strb_f |=> latch_q == $past(latch_q))
		else $error("latch changed with strobe low");

endmodule
`default_nettype wire

// File: tb/serial_host.sv
`default_nettype none
module serial_host (
	input  wire logic clk_in,
	output logic      sclk_out,
	output logic      sdata_out,
	output logic      zero_out,
	output logic      strobe_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// serial clock rests low outside frames
	initial begin
		sclk_out = 1'b0;
		sdata_out = 1'b0;
		zero_out = 1'b0;
		strobe_out = 1'b0;
	end
	// msb first so the first bit lands in channel 7
	task automatic send_byte(input logic [7:0] b, input int half);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk_in) #1 sdata_out <= b[i];
			repeat (half) @(posedge clk_in);
			#1 sclk_out <= 1'b1;
			repeat (half) @(posedge clk_in);
			#1 sclk_out <= 1'b0;
			sdata_out <= ~b[i]; // hold over, stale level inverted
		end
	endtask
	task automatic pulse_strobe();
		@(posedge clk_in) #1 strobe_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		#1 strobe_out <= 1'b0;
	endtask
	// zeroing acts through the register, so clock it then strobe
	task automatic clear_all();
		@(posedge clk_in) #1 zero_out <= 1'b1;
		send_byte(8'hff, 4);
		@(posedge clk_in) #1 zero_out <= 1'b0;
		pulse_strobe();
	endtask
endmodule
`default_nettype wire

// File: tb/test_serial_latched_driver_ctrl.sv
`default_nettype none
module test_serial_latched_driver_ctrl
	import latched_driver_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic                mclk, rst_n, oe, ot, lsl, so, fn, foe;
	logic [CHANNELS-1:0] oc, ch;
	wire logic           sclk, sdat, zero, strb;
	int                  fail_count, checks;
	serial_host u_host (.clk_in(mclk), .sclk_out(sclk), .sdata_out(sdat),
		.zero_out(zero), .strobe_out(strb));
	serial_latched_driver_ctrl u_dut (.mclk_in(mclk), .rst_n_in(rst_n),
		.sclk_in(sclk), .sdata_in(sdat), .zero_in(zero), .strobe_in(strb),
		.oe_reset_in(oe), .overcurrent_in(oc), .overtemp_in(ot),
		.low_supply_lockout_in(lsl), .channel_on_out(ch), .sdata_out(so),
		.fault_flag_n_out(fn), .fault_flag_oe_out(foe));
	// free-running system clock
	initial mclk = 1'b0;
	always #5 mclk = ~mclk;
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// pins pass synchronisers, so allow generous settling
	task automatic settle();
		cyc(12);
	endtask
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic t_load();
		u_host.send_byte(8'ha5, 4);
		u_host.pulse_strobe();
		settle();
		chk("channels", 8'ha5, ch);
		chk("serial out", 8'h01, {7'h0, so});
		u_host.send_byte(8'h3c, 3);
		settle();
		chk("channels", 8'ha5, ch);
		chk("serial out", 8'h00, {7'h0, so});
		$display("done: load");
	endtask
	task automatic t_enable();
		oe = 1'b1;
		settle();
		chk("channels", 8'h00, ch);
		oe = 1'b0;
		settle();
		chk("channels", 8'ha5, ch);
		u_host.pulse_strobe();
		settle();
		chk("channels", 8'h3c, ch);
		$display("done: enable");
	endtask
	task automatic t_zero();
		u_host.clear_all();
		settle();
		chk("channels", 8'h00, ch);
		chk("serial out", 8'h00, {7'h0, so});
		$display("done: zero");
	endtask
	task automatic t_ovc();
		u_host.send_byte(8'hff, 4);
		u_host.pulse_strobe();
		oc = 8'h04;
		cyc(199); // just under the filter time, must not trip
		oc = 8'h00;
		settle();
		chk("channels", 8'hff, ch);
		chk("flag", 8'h00, {7'h0, foe});
		oc = 8'h04;
		cyc(260);
		chk("channels", 8'hfb, ch);
		chk("flag", 8'h01, {7'h0, foe});
		chk("flag data", 8'h00, {7'h0, fn});
		oc = 8'h00;
		settle();
		chk("channels", 8'hfb, ch);
		oe = 1'b1;
		cyc(4);
		oe = 1'b0;
		settle();
		chk("channels", 8'hff, ch);
		chk("flag", 8'h00, {7'h0, foe});
		$display("done: overcurrent");
	endtask
	task automatic t_temp_supply();
		ot = 1'b1;
		settle();
		chk("channels", 8'h00, ch);
		chk("flag", 8'h01, {7'h0, foe});
		ot = 1'b0;
		settle();
		chk("channels", 8'hff, ch);
		chk("flag", 8'h00, {7'h0, foe});
		lsl = 1'b1;
		settle();
		chk("channels", 8'h00, ch);
		lsl = 1'b0;
		settle();
		chk("channels", 8'hff, ch);
		// a latched trip is cleared by lockout just as by enable/reset
		oc = 8'h04;
		cyc(260);
		lsl = 1'b1;
		cyc(4);
		oc = 8'h00;
		cyc(4);
		lsl = 1'b0;
		settle();
		chk("channels", 8'hff, ch);
		chk("flag", 8'h00, {7'h0, foe});
		$display("done: temperature and supply");
	endtask
	// hang guard, far beyond the roughly 1200 cycles needed
	initial begin
		#200_000;
		fail_count++;
		end_of_test();
	end
	initial begin
		{rst_n, oe, ot, lsl, oc, fail_count, checks} = '0;
		cyc(10);
		rst_n = 1'b1;
		cyc(4);
		t_load();
		t_enable();
		t_zero();
		t_ovc();
		t_temp_supply();
		end_of_test();
	end
endmodule
`default_nettype wire
